// ---- rtl/fpa_pkg.sv ----
// package for the fixed-point arithmetic datapath: widths, opcodes, resets
package fpa_pkg;

  localparam int WORD_W   = 16;
  localparam int PROD_W   = 32;
  localparam int RESULT_W = 40;
  localparam int SIGN_BIT = 15;

  localparam logic [15:0] WORD_RESET   = 16'h0000;
  localparam logic [39:0] RESULT_RESET = 40'h00_0000_0000;

  typedef enum logic [3:0] {
    ALU_ADD    = 4'b0000,
    ALU_ADDC   = 4'b0001,
    ALU_SUB    = 4'b0010,
    ALU_SUBC   = 4'b0011,
    ALU_AND    = 4'b0100,
    ALU_OR     = 4'b0101,
    ALU_XOR    = 4'b0110,
    ALU_NOT    = 4'b0111,
    ALU_PASS   = 4'b1000,
    ALU_SIGNED_DIVIDE_STEP   = 4'b1001
  } fpa_alu_op_type;

  typedef enum logic [2:0] {
    MUL_SS     = 3'b000,
    MUL_UU     = 3'b001,
    MUL_SU     = 3'b010,
    MUL_US     = 3'b011,
    MUL_RND    = 3'b100
  } fpa_mul_mode_type;

  localparam logic [39:0] ROUND_BIAS = 40'h00_0000_8000;

endpackage : fpa_pkg

// ---- rtl/fpa_mul_array.sv ----
// multiplier array: raw 32-bit product with per-instruction signedness
`timescale 1ns/10ps
module fpa_mul_array #(
  parameter int WIDTH = 16
) (
  input  wire logic [WIDTH-1:0]        opX,
  input  wire logic [WIDTH-1:0]        opY,
  input  wire fpa_pkg::fpa_mul_mode_type mode,
  output logic      [2*WIDTH-1:0]      product
);
  import fpa_pkg::*;

  // each operand is widened by one bit so one signed multiply covers all
  // four signedness combinations
  wire              xSigned;
  wire              ySigned;
  wire [WIDTH:0]    xExt;
  wire [WIDTH:0]    yExt;
  wire [2*WIDTH+1:0] fullProd;

  assign xSigned  = (mode == MUL_SS) || (mode == MUL_SU) ||
                    (mode == MUL_RND);                    // [RQ10]
  assign ySigned  = (mode == MUL_SS) || (mode == MUL_US) ||
                    (mode == MUL_RND);                    // [RQ10]
  assign xExt     = {xSigned & opX[WIDTH-1], opX};
  assign yExt     = {ySigned & opY[WIDTH-1], opY};
  assign fullProd = $signed(xExt) * $signed(yExt);
  // only the low bits are a raw pattern; interpretation happens later
  assign product  = fullProd[2*WIDTH-1:0];                // [RQ10]

endmodule // fpa_mul_array

// ---- rtl/fixed_point_arith.sv ----
// fixed-point arithmetic unit and multiplier result path with status flags
//
// Function
// RQ1: the datapath works on 16-bit fixed-point words and supports multiword carry chains and signed results for block floating point.
// RQ2: logical operations treat all sixteen bits as a plain pattern without sign or binary point.
// RQ3: signed values are two's complement with the msb as sign, never signed magnitude.
// RQ4: fractions are 1.15 two's complement, from minus one to one lsb below plus one.
// RQ5: the arithmetic unit treats words as unsigned patterns except in the signed divide step.
// RQ6: the zero and negative flags read the result as a signed two's-complement value.
// RQ7: overflow is flagged when the result sign disagrees with what operand signs predict.
// RQ8: carry is the unsigned carry out of the most significant bit.
// RQ9: lower words of multiword numbers are unsigned, so carry between words is unsigned.
// RQ10: the multiplier yields a raw product with operands interpreted per instruction mode.
// RQ11: a product loaded into the result register is sign-extended across all 40 bits.
// RQ12: the product is always shifted left one bit, turning 2.30 into 1.31.
// RQ13: negative equals result bit 15 and zero is set only when all sixteen bits are zero.
`timescale 1ns/10ps
module fixed_point_arith #(
  parameter int WIDTH = fpa_pkg::WORD_W
) (
  input  wire logic                     mclk,
  input  wire logic                     sys_rst,
  input  wire logic                     aluEn,
  input  wire fpa_pkg::fpa_alu_op_type  aluOp,
  input  wire logic [WIDTH-1:0]         aluX,
  input  wire logic [WIDTH-1:0]         aluY,
  input  wire logic                     mulEn,
  input  wire fpa_pkg::fpa_mul_mode_type mulMode,
  input  wire logic [WIDTH-1:0]         mulX,
  input  wire logic [WIDTH-1:0]         mulY,
  output logic      [WIDTH-1:0]         aluResult,
  output logic                          result_zero_flag,
  output logic                          result_negative_flag,
  output logic                          arith_overflow_flag,
  output logic                          arith_carry_flag,
  output logic      [39:0]              multiply_result_register
);
  import fpa_pkg::*;

  // ==========================================================
  // arithmetic unit: operand selection
  // ==========================================================
  logic [WIDTH-1:0] aluResult_reg;
  logic             zero_reg;
  logic             neg_reg;
  logic             ovf_reg;
  logic             carry_reg;
  logic [39:0]      mr_reg;

  wire              isSub;
  wire              isArith;
  wire              useCarry;
  wire              divsOp;
  wire [WIDTH-1:0]  yOperand;
  wire              carryIn;
  wire [WIDTH:0]    sumWide;
  wire [WIDTH-1:0]  sumWord;
  wire [WIDTH-1:0]  logicWord;

  assign divsOp   = (aluOp == ALU_SIGNED_DIVIDE_STEP);
  // signed divide step: the quotient bit is the sign disagreement of
  // the operands, so subtract only when their signs match
  assign isSub    = (aluOp == ALU_SUB) || (aluOp == ALU_SUBC) ||
                    (divsOp && (aluX[WIDTH-1] == aluY[WIDTH-1])); // [RQ5]
  assign isArith  = (aluOp == ALU_ADD) || (aluOp == ALU_ADDC) ||
                    (aluOp == ALU_SUB) || (aluOp == ALU_SUBC) || divsOp;
  assign useCarry = (aluOp == ALU_ADDC) || (aluOp == ALU_SUBC);

  // subtract as x + ~y + 1; with carry, the stored unsigned carry links
  // the lower word of a multiword number to the next one
  assign yOperand = isSub ? ~aluY : aluY;                        // [RQ3]
  assign carryIn  = useCarry ? carry_reg : isSub;                // [RQ9]
  assign sumWide  = {1'b0, aluX} + {1'b0, yOperand} +
                    {{WIDTH{1'b0}}, carryIn};                    // [RQ5]
  assign sumWord  = sumWide[WIDTH-1:0];

  // ==========================================================
  // logical operations on plain bit patterns
  // ==========================================================
  logic [WIDTH-1:0] logicSel;
  always_comb begin
    case (aluOp)
      ALU_AND: logicSel = aluX & aluY;                           // [RQ2]
      ALU_OR:  logicSel = aluX | aluY;                           // [RQ2]
      ALU_XOR: logicSel = aluX ^ aluY;                           // [RQ2]
      ALU_NOT: logicSel = ~aluX;                                 // [RQ2]
      default: logicSel = aluX;
    endcase
  end
  assign logicWord = logicSel;

  // ==========================================================
  // flags
  // ==========================================================
  wire [WIDTH-1:0] aluNext;
  wire             zeroNext;
  wire             negNext;
  wire             ovfNext;
  wire             carryNext;

  assign aluNext   = isArith ? sumWord : logicWord;              // [RQ1]
  // flags read the result as signed two's complement
  assign negNext   = aluNext[SIGN_BIT];                          // [RQ6] [RQ13]
  assign zeroNext  = (aluNext == WORD_RESET);                    // [RQ6] [RQ13]
  // overflow only when both effective addends share a sign the sum lacks;
  // mixed signs can never trip it
  assign ovfNext   = isArith &&
                     (aluX[WIDTH-1] == yOperand[WIDTH-1]) &&
                     (sumWord[WIDTH-1] != aluX[WIDTH-1]);        // [RQ7]
  assign carryNext = isArith && sumWide[WIDTH];                  // [RQ8]

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      aluResult_reg <= WORD_RESET;
      zero_reg      <= 1'b0;
      neg_reg       <= 1'b0;
      ovf_reg       <= 1'b0;
      carry_reg     <= 1'b0;
    end else if (aluEn) begin
      aluResult_reg <= aluNext;
      zero_reg      <= zeroNext;
      neg_reg       <= negNext;
      ovf_reg       <= ovfNext;
      carry_reg     <= carryNext;                                // [RQ9]
    end
  end

  // ==========================================================
  // multiplier and result register
  // ==========================================================
  wire [2*WIDTH-1:0] rawProduct;
  wire [39:0]        shiftedProd;
  wire [39:0]        roundedProd;
  wire [39:0]        mrNext;

  fpa_mul_array #(
    .WIDTH   (WIDTH)
  ) uMul (
    .opX     (mulX),
    .opY     (mulY),
    .mode    (mulMode),
    .product (rawProduct)
  );

  // 1.15 x 1.15 gives 2.30; one left shift lines it up as 1.31 so the
  // top word is a 1.15 value. integer users must shift back right.
  assign shiftedProd = {{(40-2*WIDTH){rawProduct[2*WIDTH-1]}},
                        rawProduct} <<< 1;                       // [RQ11] [RQ12] [RQ4]
  // rounding adds half an lsb of the upper word; bias-to-nearest only
  assign roundedProd = shiftedProd + ROUND_BIAS;
  assign mrNext      = (mulMode == MUL_RND) ? roundedProd : shiftedProd;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mr_reg <= RESULT_RESET;
    end else if (mulEn) begin
      mr_reg <= mrNext;                                          // [RQ11]
    end
  end

  assign aluResult                = aluResult_reg;
  assign result_zero_flag         = zero_reg;
  assign result_negative_flag     = neg_reg;
  assign arith_overflow_flag      = ovf_reg;
  assign arith_carry_flag         = carry_reg;
  assign multiply_result_register = mr_reg;

endmodule // fixed_point_arith

// ---- dv/fpa_checker.sv ----
// assertions on the ports of the fixed-point arithmetic datapath
`timescale 1ns/10ps
module fpa_checker #(parameter int WIDTH = 16) (
  input wire logic mclk, sys_rst, aluEn, mulEn,
  input wire fpa_pkg::fpa_alu_op_type aluOp,
  input wire fpa_pkg::fpa_mul_mode_type mulMode,
  input wire logic [WIDTH-1:0] aluX, aluY, mulX, mulY, aluResult,
  input wire logic result_zero_flag, result_negative_flag,
  input wire logic arith_overflow_flag, arith_carry_flag,
  input wire logic [39:0] multiply_result_register);
  import fpa_pkg::*;
  wire logic [16:0] addSum = {1'b0, aluX} + {1'b0, aluY};
  wire logic signed [31:0] prodSs = $signed(mulX) * $signed(mulY);
  // =========================================================
  // properties
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  neg_is_msb_a: assert property (aluEn |=>
    result_negative_flag == aluResult[15]) else $error("negative flag wrong");
  zero_all_bits_a: assert property (aluEn |=>
    result_zero_flag == (aluResult == '0)) else $error("zero flag wrong");
  add_carry_a: assert property (aluEn && aluOp == ALU_ADD |=>
    {arith_carry_flag, aluResult} == $past(addSum)) else $error("add wrong");
  add_overflow_a: assert property (aluEn && aluOp == ALU_ADD |=>
    arith_overflow_flag == $past(aluX[15] == aluY[15] &&
    addSum[15] != aluX[15])) else $error("overflow flag wrong");
  logic_no_flags_a: assert property (aluEn &&
    aluOp inside {ALU_AND, ALU_OR, ALU_XOR, ALU_NOT} |=>
    !arith_overflow_flag && !arith_carry_flag) else $error("logic op flags");
  xor_pattern_a: assert property (aluEn && aluOp == ALU_XOR |=>
    aluResult == $past(aluX ^ aluY)) else $error("xor result wrong");
  idle_hold_a: assert property (!aluEn |=>
    $stable(aluResult) && $stable(arith_carry_flag)) else $error("idle change");
  mul_signed_a: assert property (mulEn && mulMode == MUL_SS |=>
    multiply_result_register == $past({{7{prodSs[31]}}, prodSs, 1'b0}))
    else $error("signed product wrong");
  mul_extend_a: assert property (mulEn && mulMode != MUL_RND |=>
    multiply_result_register[39:32] inside {8'h00, 8'hFF} &&
    !multiply_result_register[0]) else $error("product not extended");
endmodule // fpa_checker
bind fixed_point_arith fpa_checker #(.WIDTH(WIDTH)) u_chk (.mclk(mclk),
  .sys_rst(sys_rst), .aluEn(aluEn), .mulEn(mulEn), .aluOp(aluOp),
  .mulMode(mulMode), .aluX(aluX), .aluY(aluY), .mulX(mulX), .mulY(mulY),
  .aluResult(aluResult), .result_zero_flag(result_zero_flag),
  .result_negative_flag(result_negative_flag),
  .arith_overflow_flag(arith_overflow_flag),
  .arith_carry_flag(arith_carry_flag),
  .multiply_result_register(multiply_result_register));

// ---- dv/fpa_decoder_model.sv ----
// decoder-side model presenting one instruction to the datapath per cycle
`timescale 1ns/10ps
module fpa_decoder_model (
  output logic aluEn, mulEn,
  output fpa_pkg::fpa_alu_op_type aluOp,
  output fpa_pkg::fpa_mul_mode_type mulMode,
  output logic [15:0] aluX, aluY, mulX, mulY);
  import fpa_pkg::*;
  initial begin
    {aluEn, mulEn, aluX, aluY, mulX, mulY} = '0;
    aluOp = ALU_PASS;
    mulMode = MUL_SS;
  end
  // called just after an edge, so each field holds a whole cycle
  task automatic issue(input logic ae, input fpa_alu_op_type op,
    input logic [15:0] x, y, input logic me, input fpa_mul_mode_type mm,
    input logic [15:0] mx, my);
    aluEn = ae;
    aluOp = op;
    {aluX, aluY} = {x, y};
    mulEn = me;
    mulMode = mm;
    {mulX, mulY} = {mx, my};
  endtask
endmodule // fpa_decoder_model

// ---- dv/fixed_point_arith_bench.sv ----
// self-checking bench for the fixed-point arithmetic datapath
`timescale 1ns/10ps
module fixed_point_arith_bench;
  import fpa_pkg::*;
  logic mclk = 0, sys_rst = 1, aluEn, mulEn, cy = 0;
  fpa_alu_op_type aluOp;
  fpa_mul_mode_type mulMode;
  logic [15:0] aluX, aluY, mulX, mulY, aluResult;
  logic zf, nf, vf, cf;
  logic [39:0] mr, expMr = '0;
  logic [19:0] expAlu = '0, aluMask;
  int n_mismatch = 0, comparisons = 0, cycles = 0;
  fpa_alu_op_type opTab [12] = '{ALU_ADD, ALU_ADD, ALU_ADDC, ALU_SUB,
    ALU_SUBC, ALU_ADD, ALU_AND, ALU_OR, ALU_XOR, ALU_NOT, ALU_SIGNED_DIVIDE_STEP, ALU_PASS};
  logic [15:0] xTab [12] = '{16'h7FFF, 16'hFFFF, 16'h0000, 16'h0000,
    16'h0005, 16'h8000, 16'hF0F0, 16'hF0F0, 16'hF0F0, 16'h1234, 16'h8000,
    16'h1234};
  logic [15:0] yTab [12] = '{16'h0001, 16'h0001, 16'h0000, 16'h0001,
    16'h0002, 16'h8000, 16'hFF00, 16'hFF00, 16'hFF00, 16'h0000, 16'h4000,
    16'h8000};
  always #25 mclk = ~mclk;
  fpa_decoder_model dec (.aluEn(aluEn), .mulEn(mulEn), .aluOp(aluOp),
    .mulMode(mulMode), .aluX(aluX), .aluY(aluY), .mulX(mulX), .mulY(mulY));
  fixed_point_arith uut (.mclk(mclk), .sys_rst(sys_rst), .aluEn(aluEn),
    .aluOp(aluOp), .aluX(aluX), .aluY(aluY), .mulEn(mulEn),
    .mulMode(mulMode), .mulX(mulX), .mulY(mulY), .aluResult(aluResult),
    .result_zero_flag(zf), .result_negative_flag(nf),
    .arith_overflow_flag(vf), .arith_carry_flag(cf),
    .multiply_result_register(mr));
  // =========================================================
  // reference models
  function automatic logic [19:0] alu_ref(input fpa_alu_op_type op,
    input logic [15:0] x, y, input logic ci);
    logic [16:0] s;
    logic [15:0] yy, r;
    logic sb, c0, ar;
    sb = op inside {ALU_SUB, ALU_SUBC} || (op == ALU_SIGNED_DIVIDE_STEP && x[15] == y[15]);
    c0 = op inside {ALU_ADDC, ALU_SUBC} ? ci : sb;
    yy = sb ? ~y : y;
    s = {1'b0, x} + {1'b0, yy} + {16'h0000, c0};
    ar = op inside {ALU_ADD, ALU_ADDC, ALU_SUB, ALU_SUBC, ALU_SIGNED_DIVIDE_STEP};
    case (op)
      ALU_AND: r = x & y;
      ALU_OR: r = x | y;
      ALU_XOR: r = x ^ y;
      ALU_NOT: r = ~x;
      ALU_PASS: r = x;
      default: r = s[15:0];
    endcase
    return {r == 16'h0000, r[15], ar && x[15] == yy[15] && s[15] != x[15],
      ar && s[16], r};
  endfunction
  function automatic logic [39:0] mul_ref(input fpa_mul_mode_type m,
    input logic [15:0] x, y);
    logic signed [33:0] p;
    p = $signed({!(m inside {MUL_UU, MUL_US}) && x[15], x}) *
      $signed({!(m inside {MUL_UU, MUL_SU}) && y[15], y});
    return {{7{p[31]}}, p[31:0], 1'b0} + (m == MUL_RND ? 40'h00_0000_8000 : 40'h0);
  endfunction
  task automatic check(input string what, input logic [39:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input logic ae, input fpa_alu_op_type op,
    input logic [15:0] x, y, input logic me, input fpa_mul_mode_type mm,
    input logic [15:0] mx, my);
    dec.issue(ae, op, x, y, me, mm, mx, my);
    @(posedge mclk);
    #1;
    if (ae) begin
      expAlu = alu_ref(op, x, y, cy);
      // the divide step is an add or subtract, so its carry feeds addc
      aluMask = 20'hF_FFFF;
      cy = expAlu[16];
    end
    if (me) expMr = mul_ref(mm, mx, my);
    check("alu", {zf, nf, vf, cf, aluResult} & aluMask, expAlu & aluMask);
    check("product", mr, expMr);
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    aluMask = 20'hF_FFFF;
    void'($urandom(24));
    repeat (3) @(posedge mclk);
    #1 sys_rst = 0;
    for (int i = 0; i < 12; i++)
      step(1, opTab[i], xTab[i], yTab[i], 1, fpa_mul_mode_type'(i % 5), xTab[i], yTab[i]);
    repeat (400)
      step($urandom % 2, fpa_alu_op_type'($urandom % 9), 16'($urandom),
        16'($urandom), $urandom % 2, fpa_mul_mode_type'($urandom % 5),
        16'($urandom), 16'($urandom));
    stop_test();
  end
endmodule // fixed_point_arith_bench
